// *** include/pulse_input_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the pulse input bank.
// Included by the design modules and the bench; definitions only.
`ifndef PULSE_INPUT_REGS_SVH
`define PULSE_INPUT_REGS_SVH

// Register byte offsets
`define PIN_OFS_CTRL       12'h000
`define PIN_OFS_STATUS     12'h004
`define PIN_OFS_INT_STAT   12'h008
`define PIN_OFS_INT_MASK   12'h00C
`define PIN_OFS_DEMAND_CNT 12'h010
`define PIN_OFS_CHAN_CFG   12'h014
`define PIN_OFS_CFG0       12'h020
`define PIN_OFS_COUNT0     12'h040
`define PIN_OFS_ACCUM0     12'h060

// Per-input config fields
`define PIN_CFG_DEB_LSB    0
`define PIN_CFG_DEB_MSB    6
`define PIN_CFG_MODE_LSB   8
`define PIN_CFG_MODE_MSB   9
`define PIN_CFG_ALARM_BIT  10
`define PIN_CFG_WEIGHT_LSB 16
`define PIN_CFG_WEIGHT_MSB 31

// Channel config fields
`define PIN_CHAN_SET_LSB   0
`define PIN_CHAN_SET_MSB   3
`define PIN_CHAN_EDGE_BIT  4

// Ctrl fields
`define PIN_CTRL_FOUR_BIT  0

// Reset values
`define PIN_CTRL_RESET     32'h0000_0001
`define PIN_CFG_RESET      32'h0001_0001
`define PIN_CHAN_RESET     32'h0000_0000

// Timing
`define PIN_CLK_MHZ        125
`define PIN_TICK_US        1000
`define PIN_TICK_CYCLES    (`PIN_TICK_US * `PIN_CLK_MHZ)
`define PIN_DEB_STEP_MS    10
`define PIN_DEB_MAX_MS     1000
`define PIN_DEB_MAX_UNITS  (`PIN_DEB_MAX_MS / `PIN_DEB_STEP_MS)

`endif

// *** include/pulse_input_pkg.sv ***
// Types shared by the pulse input bank modules.
// Assumes pulse_input_regs.svh for all figures.
package pulse_input_pkg;

    typedef enum logic [1:0]
    {
        MODE_PLAIN  = 2'b00,
        MODE_DEMAND = 2'b01,
        MODE_METER  = 2'b10,
        MODE_TARIFF = 2'b11
    } input_mode_t;

    typedef struct packed
    {
        logic [15:0] weight;
        logic        alarm_en;
        input_mode_t mode;
        logic [6:0]  deb_units;
    } input_cfg_t;

    typedef struct packed
    {
        logic level;
        logic rise;
        logic fall;
    } input_event_t;

endpackage

// *** verilog/ms_tick_gen.sv ***
// One-millisecond tick from the 125 MHz pclk.
// Assumes pclk runs free; tick is a single-cycle pulse.
`include "pulse_input_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module ms_tick_gen
#(
    parameter int unsigned TICK_CYCLES = `PIN_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Tick out
    output var  logic tick_q
);

    logic [16:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= 17'h00000;
            tick_q <= 1'b0;
        end
        else if (cnt_q == 17'(TICK_CYCLES - 1))
        begin
            cnt_q  <= 17'h00000;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 17'h00001;
            tick_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** verilog/input_debouncer.sv ***
// Debounce filter for one pulse input: accepts a level after it has been stable.
// Assumes input is synchronous to pclk and tick is a 1 ms single-cycle pulse.
`include "pulse_input_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module input_debouncer
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // Timebase and setting, in 10 ms units
    input  wire logic                       tick,
    input  wire logic [6:0]                 deb_units,
    // Raw level and filtered events
    input  wire logic                       raw,
    output var pulse_input_pkg::input_event_t evt
);

    logic [9:0] ms_q;
    logic       level_q;
    logic       rise_q;
    logic       fall_q;
    logic [9:0] need_ms;
    logic       diff;

    // Out-of-range settings clamp to the maximum
    assign need_ms = (deb_units > 7'(`PIN_DEB_MAX_UNITS)) ? 10'(`PIN_DEB_MAX_MS)
                   : 10'(deb_units) * 10'(`PIN_DEB_STEP_MS);
    assign diff    = (raw != level_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ms_q <= 10'h000;
        else if (!diff)
            ms_q <= 10'h000;
        else if (tick && ms_q != 10'h3FF)
            ms_q <= ms_q + 10'h001;
    end

    // accept after stable time; zero bypasses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end
        else if (diff && (need_ms == 10'h000 || (tick && ms_q + 10'h001 >= need_ms)))
        begin
            level_q <= raw;
            rise_q  <= raw;
            fall_q  <= !raw;
        end
        else
        begin
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end
    end

    assign evt = '{level: level_q, rise: rise_q, fall: fall_q};

    // no accepted rise without a matching raw high level
    a_accept_follows_raw: assert property (@(posedge pclk) disable iff (!presetn)
        evt.rise |-> $past(raw))
        else $error("accepted rise without raw high");

    a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
        $past(raw) == $past(level_q) |-> ms_q == 10'h000)
        else $error("stability timer not restarted");

endmodule

`default_nettype wire

// *** verilog/pulse_input_bank.sv ***
// Debounced pulse input bank with APB registers, per-input function routing,
// pulse counters, metering channel accumulation and a level interrupt.
// Assumes inputs synchronous to pclk, a 125 MHz pclk, and an APB master.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`include "pulse_input_regs.svh"
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - four inputs; reduced variant uses two
// - level valid after stable for set time
// - time in 10 ms steps, max 1000
// - plain mode counts every validated pulse
// - plain mode may raise per-input alarm
// - demand mode pulse realigns demand interval
// - meter mode counts and accumulates quantity
// - tariff mode routes level to tariff logic
// - channel accumulates from assigned input set
// - channel counts pulses or each transition
module pulse_input_bank
#(
    parameter int unsigned TICK_CYCLES = `PIN_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Contact inputs
    input  wire logic        pulse_input_one,
    input  wire logic        pulse_input_two,
    input  wire logic        pulse_input_three,
    input  wire logic        pulse_input_four,
    // Function outputs
    output var  logic        demand_sync_q,
    output var  logic [3:0]  tariff_sel_q,
    output var  logic [3:0]  alarm_q,
    output var  logic        irq_q
);

    localparam int N = 4;
    // Reset word is in register layout; repacked below exactly like a write
    localparam logic [31:0] CFG_RST = `PIN_CFG_RESET;

    logic [N-1:0]                        raw;
    logic                                tick;
    pulse_input_pkg::input_cfg_t         cfg_q   [N];
    pulse_input_pkg::input_event_t       evt     [N];
    logic [31:0]                         count_q [N];
    logic [31:0]                         accum_q;
    logic [31:0]                         demand_cnt_q;
    logic [4:0]                          chan_q;
    logic                                four_q;
    logic [N-1:0]                        active;
    logic [N-1:0]                        valid_pulse;
    logic [N-1:0]                        chan_hit;
    logic [7:0]                          int_stat_q;
    logic [7:0]                          int_mask_q;
    logic [7:0]                          int_set;
    logic                                wr_en;
    logic                                rd_en;
    logic [31:0]                         rd_d;
    logic                                err_d;
    logic [31:0]                         weight_sum;

    assign raw = {pulse_input_four, pulse_input_three, pulse_input_two, pulse_input_one};

    // Zero-wait APB: every access completes in its first access cycle
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    ms_tick_gen
    #(
        .TICK_CYCLES (TICK_CYCLES)
    )
    u_tick
    (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_q  (tick)
    );

    // upper pair disabled in reduced variant
    assign active = four_q ? 4'hF : 4'h3;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_in
            input_debouncer u_deb
            (
                .pclk      (pclk),
                .presetn   (presetn),
                .tick      (tick),
                .deb_units (cfg_q[gi].deb_units),
                .raw       (raw[gi] & active[gi]),
                .evt       (evt[gi])
            );

            assign valid_pulse[gi] = evt[gi].rise && active[gi];

            assign chan_hit[gi] = chan_q[`PIN_CHAN_SET_LSB + gi] && active[gi]
                && cfg_q[gi].mode == pulse_input_pkg::MODE_METER
                && (evt[gi].rise || (chan_q[`PIN_CHAN_EDGE_BIT] && evt[gi].fall));

            // counting in plain and meter modes
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    count_q[gi] <= 32'h0000_0000;
                else if (wr_en && paddr == `PIN_OFS_COUNT0 + 12'(4 * gi))
                    count_q[gi] <= pwdata;
                else if (valid_pulse[gi]
                         && (cfg_q[gi].mode == pulse_input_pkg::MODE_PLAIN
                             || cfg_q[gi].mode == pulse_input_pkg::MODE_METER))
                    count_q[gi] <= count_q[gi] + 32'h0000_0001;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cfg_q[gi] <= pulse_input_pkg::input_cfg_t'({CFG_RST[31:16],
                        CFG_RST[10:8], CFG_RST[6:0]});
                else if (wr_en && paddr == `PIN_OFS_CFG0 + 12'(4 * gi))
                    cfg_q[gi] <= pulse_input_pkg::input_cfg_t'({pwdata[31:16],
                        pwdata[10:8], pwdata[6:0]});
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    alarm_q[gi] <= 1'b0;
                else
                    alarm_q[gi] <= evt[gi].level && cfg_q[gi].alarm_en && active[gi]
                        && cfg_q[gi].mode == pulse_input_pkg::MODE_PLAIN;
            end

            // tariff gets level only in tariff mode
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    tariff_sel_q[gi] <= 1'b0;
                else
                    tariff_sel_q[gi] <= evt[gi].level && active[gi]
                        && cfg_q[gi].mode == pulse_input_pkg::MODE_TARIFF;
            end

            assign int_set[gi]     = valid_pulse[gi];
            assign int_set[gi + 4] = alarm_q[gi] == 1'b0 && evt[gi].rise
                && cfg_q[gi].alarm_en && cfg_q[gi].mode == pulse_input_pkg::MODE_PLAIN;
        end
    endgenerate

    // Weighted sum of channel hits this cycle
    always_comb
    begin
        weight_sum = 32'h0000_0000;
        for (int i = 0; i < N; i++)
        begin
            if (chan_hit[i])
                weight_sum = weight_sum + {16'h0000, cfg_q[i].weight};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            accum_q <= 32'h0000_0000;
        else if (wr_en && paddr == `PIN_OFS_ACCUM0)
            accum_q <= pwdata;
        else
            accum_q <= accum_q + weight_sum;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            demand_sync_q <= 1'b0;
            demand_cnt_q  <= 32'h0000_0000;
        end
        else
        begin
            demand_sync_q <= 1'b0;
            for (int i = 0; i < N; i++)
            begin
                if (valid_pulse[i] && cfg_q[i].mode == pulse_input_pkg::MODE_DEMAND)
                    demand_sync_q <= 1'b1;
            end
            if (|(valid_pulse & {cfg_q[3].mode == pulse_input_pkg::MODE_DEMAND,
                                 cfg_q[2].mode == pulse_input_pkg::MODE_DEMAND,
                                 cfg_q[1].mode == pulse_input_pkg::MODE_DEMAND,
                                 cfg_q[0].mode == pulse_input_pkg::MODE_DEMAND}))
                demand_cnt_q <= demand_cnt_q + 32'h0000_0001;
        end
    end

    // Control and channel config
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            four_q <= 1'(`PIN_CTRL_RESET);
            chan_q <= 5'(`PIN_CHAN_RESET);
        end
        else if (wr_en && paddr == `PIN_OFS_CTRL)
            four_q <= pwdata[`PIN_CTRL_FOUR_BIT];
        else if (wr_en && paddr == `PIN_OFS_CHAN_CFG)
            chan_q <= pwdata[`PIN_CHAN_EDGE_BIT:`PIN_CHAN_SET_LSB];
    end

    // Sticky status; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_stat_q <= 8'h00;
        else if (wr_en && paddr == `PIN_OFS_INT_STAT)
            int_stat_q <= (int_stat_q & ~pwdata[7:0]) | int_set;
        else
            int_stat_q <= int_stat_q | int_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_mask_q <= 8'h00;
        else if (wr_en && paddr == `PIN_OFS_INT_MASK)
            int_mask_q <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(int_stat_q & int_mask_q);
    end

    // Read mux; unmapped addresses answer with an error
    always_comb
    begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        unique case (paddr)
            `PIN_OFS_CTRL:       rd_d = {31'h0, four_q};
            `PIN_OFS_STATUS:     rd_d = {24'h0, alarm_q, evt[3].level, evt[2].level,
                                         evt[1].level, evt[0].level};
            `PIN_OFS_INT_STAT:   rd_d = {24'h0, int_stat_q};
            `PIN_OFS_INT_MASK:   rd_d = {24'h0, int_mask_q};
            `PIN_OFS_DEMAND_CNT: rd_d = demand_cnt_q;
            `PIN_OFS_CHAN_CFG:   rd_d = {27'h0, chan_q};
            12'h020, 12'h024, 12'h028, 12'h02C:
                rd_d = {cfg_q[paddr[3:2]].weight, 5'h00,
                        cfg_q[paddr[3:2]].alarm_en, cfg_q[paddr[3:2]].mode,
                        1'b0, cfg_q[paddr[3:2]].deb_units};
            12'h040, 12'h044, 12'h048, 12'h04C:
                rd_d = count_q[paddr[3:2]];
            `PIN_OFS_ACCUM0:     rd_d = accum_q;
            default:             err_d = 1'b1;
        endcase
    end

    // Read data captured in setup so it is valid during access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && err_d;
            if (rd_en)
                prdata <= rd_d;
        end
    end

    a_count_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        count_q[0] == 32'hFFFF_FFFF && valid_pulse[0] && !wr_en
        && cfg_q[0].mode == pulse_input_pkg::MODE_PLAIN |=> count_q[0] == 32'h0000_0000)
        else $error("counter did not wrap");

    // tariff output only in tariff mode
    a_tariff_route: assert property (@(posedge pclk) disable iff (!presetn)
        tariff_sel_q[3] |-> $past(cfg_q[3].mode) == pulse_input_pkg::MODE_TARIFF)
        else $error("tariff driven outside tariff mode");

    a_demand_sync: assert property (@(posedge pclk) disable iff (!presetn)
        valid_pulse[2] && cfg_q[2].mode == pulse_input_pkg::MODE_DEMAND |=> demand_sync_q)
        else $error("demand sync missing");

    a_reduced_pair: assert property (@(posedge pclk) disable iff (!presetn)
        !four_q |-> !valid_pulse[3] && !valid_pulse[2])
        else $error("upper input active in reduced mode");

    a_accum_step: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_en |=> accum_q == $past(accum_q) + $past(weight_sum))
        else $error("accumulator step wrong");

endmodule

`default_nettype wire

// *** verification/contact_model.sv ***
// Far-side model: four dry contacts with optional mechanical chatter.
// Assumes the bench changes target just after a rising pclk edge.
`timescale 1ns/10ps
`default_nettype none

module contact_model
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Requested contact state
    input  wire logic [3:0] target,
    input  wire logic       bounce,
    // Contact levels
    output var  logic [3:0] contact
);
    logic [3:0] last_q;
    logic [3:0] chg_q;
    logic [3:0] left_q;

    // Chatter toggles the moving contacts for 8 cycles, then settles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            contact <= 4'h0;
            last_q  <= 4'h0;
            chg_q   <= 4'h0;
            left_q  <= 4'h0;
        end
        else if (target != last_q)
        begin
            last_q  <= target;
            chg_q   <= target ^ last_q;
            left_q  <= bounce ? 4'h8 : 4'h0;
            contact <= bounce ? (contact ^ (target ^ last_q)) : target;
        end
        else if (left_q != 4'h0)
        begin
            left_q  <= left_q - 4'h1;
            contact <= (left_q == 4'h1) ? last_q : (contact ^ chg_q);
        end
    end
endmodule

`default_nettype wire

// *** verification/pulse_input_bank_tb.sv ***
// Self-checking bench for the pulse input bank: APB tasks and a contact model.
// Assumes TICK_CYCLES of 10, so one 10 ms debounce unit is 100 pclk cycles.
`include "pulse_input_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module pulse_input_bank_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  target;
    logic        bounce;
    logic [3:0]  contact;
    logic        demand_sync_q;
    logic [3:0]  tariff_sel_q;
    logic [3:0]  alarm_q;
    logic        irq_q;
    logic [31:0] rd;
    logic        rerr;
    int          err_total;
    int          n_checks;
    int          dsync_seen;
    int          cyc = 0;

    pulse_input_bank #(.TICK_CYCLES(10)) dut
    (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .pulse_input_one   (contact[0]),
        .pulse_input_two   (contact[1]),
        .pulse_input_three (contact[2]),
        .pulse_input_four  (contact[3]),
        .demand_sync_q     (demand_sync_q),
        .tariff_sel_q      (tariff_sel_q),
        .alarm_q           (alarm_q),
        .irq_q             (irq_q)
    );

    contact_model partner
    (
        .pclk    (pclk),
        .presetn (presetn),
        .target  (target),
        .bounce  (bounce),
        .contact (contact)
    );

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard, well above the fewer than a thousand cycles the tests need
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    always @(posedge pclk)
        if (demand_sync_q === 1'b1)
            dsync_seen++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        target[i] <= 1'b1;
        wt(6);
        target[i] <= 1'b0;
        wt(6);
    endtask

    function automatic logic [31:0] cfg(logic [15:0] w, logic al,
                                       pulse_input_pkg::input_mode_t m, logic [6:0] u);
        return {w, 5'h00, al, m, 1'b0, u};
    endfunction

    initial
    begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0;
        target     = 4'h0;
        bounce     = 1'b0;
        err_total  = 0;
        n_checks   = 0;
        dsync_seen = 0;
        wt(5);
        presetn <= 1'b1;
        rchk(`PIN_OFS_CTRL, `PIN_CTRL_RESET);
        rchk(`PIN_OFS_CFG0 + 12'h00C, `PIN_CFG_RESET);
        rchk(`PIN_OFS_CHAN_CFG, `PIN_CHAN_RESET);
        rchk(12'h0FC, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // Zero setting passes edges straight through
        wr(`PIN_OFS_CFG0, cfg(16'h1, 1'b0, pulse_input_pkg::MODE_PLAIN, 7'h00));
        pulse(0);
        rchk(`PIN_OFS_COUNT0, 32'h1);
        rchk(`PIN_OFS_INT_STAT, 32'h1);
        wr(`PIN_OFS_COUNT0, 32'hFFFF_FFFF);
        pulse(0);
        rchk(`PIN_OFS_COUNT0, 32'h0);
        // Metering channel, pulse then transition counting
        wr(`PIN_OFS_CFG0, cfg(16'h5, 1'b0, pulse_input_pkg::MODE_METER, 7'h00));
        wr(`PIN_OFS_ACCUM0, 32'h0);
        wr(`PIN_OFS_CHAN_CFG, 32'h1);
        pulse(0);
        rchk(`PIN_OFS_ACCUM0, 32'h5);
        rchk(`PIN_OFS_COUNT0, 32'h1);
        wr(`PIN_OFS_CHAN_CFG, 32'h11);
        pulse(0);
        rchk(`PIN_OFS_ACCUM0, 32'hF);
        wr(`PIN_OFS_CFG0 + 12'h004, cfg(16'h7, 1'b0, pulse_input_pkg::MODE_METER, 7'h00));
        pulse(1);
        rchk(`PIN_OFS_ACCUM0, 32'hF);
        wr(`PIN_OFS_CHAN_CFG, 32'h13);
        pulse(1);
        rchk(`PIN_OFS_ACCUM0, 32'h1D);
        wr(`PIN_OFS_CHAN_CFG, 32'h0);
        // Demand and tariff routing
        wr(`PIN_OFS_CFG0 + 12'h008, cfg(16'h1, 1'b0, pulse_input_pkg::MODE_DEMAND, 7'h00));
        pulse(2);
        rchk(`PIN_OFS_DEMAND_CNT, 32'h1);
        chk(dsync_seen, 32'h1);
        rchk(`PIN_OFS_COUNT0 + 12'h008, 32'h0);
        wr(`PIN_OFS_CFG0 + 12'h00C, cfg(16'h1, 1'b0, pulse_input_pkg::MODE_TARIFF, 7'h00));
        target[3] <= 1'b1;
        wt(5);
        chk({28'h0, tariff_sel_q}, 32'h8);
        rchk(`PIN_OFS_COUNT0 + 12'h00C, 32'h0);
        target[3] <= 1'b0;
        wt(5);
        chk({28'h0, tariff_sel_q}, 32'h0);
        // Alarm, mask and write-one-to-clear
        wr(`PIN_OFS_INT_STAT, 32'hFF);
        wr(`PIN_OFS_INT_MASK, 32'h20);
        wr(`PIN_OFS_CFG0 + 12'h004, cfg(16'h1, 1'b1, pulse_input_pkg::MODE_PLAIN, 7'h00));
        target[1] <= 1'b1;
        wt(5);
        chk({28'h0, alarm_q}, 32'h2);
        chk({31'h0, irq_q}, 32'h1);
        rchk(`PIN_OFS_INT_STAT, 32'h22);
        wr(`PIN_OFS_INT_STAT, 32'h22);
        wt(3);
        chk({31'h0, irq_q}, 32'h0);
        target[1] <= 1'b0;
        wt(5);
        // One 10 ms unit with chatter: short pulse rejected, long one taken
        wr(`PIN_OFS_CFG0 + 12'h004, cfg(16'h1, 1'b0, pulse_input_pkg::MODE_PLAIN, 7'h01));
        wr(`PIN_OFS_COUNT0 + 12'h004, 32'h0);
        bounce    <= 1'b1;
        target[1] <= 1'b1;
        wt(40);
        target[1] <= 1'b0;
        wt(200);
        rchk(`PIN_OFS_COUNT0 + 12'h004, 32'h0);
        target[1] <= 1'b1;
        wt(60);
        rchk(`PIN_OFS_COUNT0 + 12'h004, 32'h0);
        wt(80);
        rchk(`PIN_OFS_COUNT0 + 12'h004, 32'h1);
        target[1] <= 1'b0;
        wt(150);
        rchk(`PIN_OFS_COUNT0 + 12'h004, 32'h1);
        bounce <= 1'b0;
        // Reduced variant ignores the upper inputs
        wr(`PIN_OFS_CTRL, 32'h0);
        wr(`PIN_OFS_CFG0 + 12'h008, cfg(16'h1, 1'b0, pulse_input_pkg::MODE_PLAIN, 7'h00));
        pulse(2);
        rchk(`PIN_OFS_COUNT0 + 12'h008, 32'h0);
        wr(`PIN_OFS_CTRL, 32'h1);
        wt(3);
        pulse(2);
        rchk(`PIN_OFS_COUNT0 + 12'h008, 32'h1);
        report_and_stop();
    end
endmodule

`default_nettype wire
